// file: test/watchdog_soft_reset_asserts.sv
`timescale 1ns/1ps
`include "wdog_consts.svh"
module watchdog_soft_reset_asserts
	import wdog_pkg::*;
#(
	parameter int BASE_CYCLES = 16384,
	parameter int CNT_W       = 21
) (
	// Clock and reset
	input wire logic  sys_clk,
	input wire logic  nrst,
	// Register port
	input wire byte_t reg_addr,
	input wire byte_t reg_wdata,
	input wire logic  reg_wr,
	input wire logic  reg_rd,
	input wire byte_t reg_rdata,
	// Device state
	input wire logic  idle_mode,
	input wire logic  chip_reset_in,
	// Outputs
	input wire logic  wd_reset_req,
	input wire logic  wd_irq,
	input wire logic  wdog_running_flag
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	byte_t first_q;
	logic  key_wr;
	logic  good_first;
	logic  sr_end;
	logic  en_end;
	// --------
	// Key pair tracking
	// --------
	assign key_wr = reg_wr && reg_addr == `WD_ADDR_KEY;
	assign good_first = first_q == 8'h00 && (reg_wdata == `WD_KEY_EN1 ||
		reg_wdata == `WD_KEY_SR1);
	assign sr_end = key_wr && first_q == `WD_KEY_SR1 && reg_wdata == `WD_KEY_SR2;
	assign en_end = key_wr && first_q == `WD_KEY_EN1 && reg_wdata == `WD_KEY_EN2;
	// Pending first byte; any reset drops it
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			first_q <= 8'h00;
		else if (chip_reset_in)
			first_q <= 8'h00;
		else if (key_wr)
			first_q <= good_first ? reg_wdata : 8'h00;
		else if (wd_reset_req)
			first_q <= 8'h00;
	end
	// Second soft byte after a tracked first byte, gaps allowed
	sequence soft_pair_s;
		sr_end && !chip_reset_in;
	endsequence
	// --------
	// Properties
	// --------
	soft_reset_a: assert property (soft_pair_s |=> wd_reset_req)
		else $error("soft key pair gave no reset pulse");
	soft_stop_a: assert property (soft_pair_s |=> !wdog_running_flag)
		else $error("soft reset left counter running");
	bad_key_a: assert property (key_wr && !good_first && !sr_end && !en_end
		|=> wd_reset_req)
		else $error("bad key gave no reset pulse");
	start_run_a: assert property (en_end && !chip_reset_in
		|=> wdog_running_flag)
		else $error("enable pair did not start counter");
	run_rise_a: assert property ($rose(wdog_running_flag) |-> $past(en_end))
		else $error("counter started without enable pair");
	chip_stop_a: assert property (chip_reset_in |=> !wdog_running_flag)
		else $error("chip reset left counter running");
	req_stop_a: assert property (wd_reset_req |-> !wdog_running_flag)
		else $error("reset pulse with counter running");
	key_read_a: assert property (reg_rd && reg_addr == `WD_ADDR_KEY
		|=> reg_rdata == 8'h00)
		else $error("key register read not zero");
	irq_rise_a: assert property ($rose(wd_irq) |-> wd_reset_req ||
		$past(wd_reset_req) || $past(reg_wr && reg_addr == `WD_ADDR_IRQ_EN) ||
		$past(reg_wr && reg_addr == `WD_ADDR_IRQ_EN, 2))
		else $error("interrupt rose without cause");
endmodule : watchdog_soft_reset_asserts

bind watchdog_soft_reset watchdog_soft_reset_asserts #(
	.BASE_CYCLES(BASE_CYCLES),
	.CNT_W      (CNT_W)
) u_watchdog_soft_reset_asserts (
	.sys_clk          (sys_clk),
	.nrst             (nrst),
	.reg_addr         (reg_addr),
	.reg_wdata        (reg_wdata),
	.reg_wr           (reg_wr),
	.reg_rd           (reg_rd),
	.reg_rdata        (reg_rdata),
	.idle_mode        (idle_mode),
	.chip_reset_in    (chip_reset_in),
	.wd_reset_req     (wd_reset_req),
	.wd_irq           (wd_irq),
	.wdog_running_flag(wdog_running_flag)
);

// file: test/watchdog_soft_reset_bench.sv
`timescale 1ns/1ps
`include "wdog_consts.svh"
module watchdog_soft_reset_bench;
	import wdog_pkg::*;
	localparam int BASE = 16;
	logic  sys_clk, nrst, reg_wr, reg_rd, idle_mode, chip_reset_in;
	byte_t reg_addr, reg_wdata, reg_rdata, b;
	logic  wd_reset_req, wd_irq, wdog_running_flag;
	int    err_total, total_checks, req_total, cyc, seed, n, k, p, r0;
	byte_t ps_tab [4] = '{8'h00, 8'h20, 8'hE0, 8'h00};
	// Short base count keeps the run brief
	watchdog_soft_reset #(.BASE_CYCLES(BASE), .CNT_W(11)) u_watchdog_soft_reset (
		.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .idle_mode(idle_mode),
		.chip_reset_in(chip_reset_in), .wd_reset_req(wd_reset_req),
		.wd_irq(wd_irq), .wdog_running_flag(wdog_running_flag));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Reset pulses seen, and a hang limit
	always @(posedge sys_clk) begin
		cyc++;
		if (wd_reset_req === 1'b1)
			req_total++;
		if (cyc == 20000) begin
			err_total++;
			close_out();
		end
	end
	// --------
	// Tasks
	// --------
	task check(input byte_t seen, input byte_t exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task wr(input byte_t a, input byte_t d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input byte_t a, input byte_t exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask : rd
	task kick();
		wr(`WD_ADDR_KEY, `WD_KEY_EN1);
		wr(`WD_ADDR_KEY, `WD_KEY_EN2);
	endtask : kick
	task chip_pulse();
		chip_reset_in <= 1'b1;
		@(posedge sys_clk);
		chip_reset_in <= 1'b0;
	endtask : chip_pulse
	// Expected period from the prescale field of a control value
	function automatic int exp_period(input byte_t ctrl);
		exp_period = BASE << ctrl[7:5];
	endfunction : exp_period
	task automatic bit_is(ref logic v, input logic exp);
		@(posedge sys_clk);
		#1;
		check({7'h00, v}, {7'h00, exp});
	endtask : bit_is
	// Keys must give exactly one reset and these flags
	task keys(input byte_t k1, input byte_t k2, input byte_t flags);
		r0 = req_total;
		wr(`WD_ADDR_CTRL, 8'h00);
		wr(`WD_ADDR_KEY, k1);
		if (k2 != 8'h00)
			wr(`WD_ADDR_KEY, k2);
		repeat (3) @(posedge sys_clk);
		check(byte_t'(req_total - r0), 8'h01);
		rd(`WD_ADDR_CTRL, flags);
	endtask : keys
	// Bounded wait; loop stops in the cycle the pulse shows
	task wait_req(input int lim);
		n = 0;
		while (wd_reset_req !== 1'b1 && n < lim) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
	endtask : wait_req
	task timeout(input byte_t ctrl, input int lim);
		wr(`WD_ADDR_CTRL, ctrl);
		kick();
		wait_req(lim);
	endtask : timeout
	task close_out();
		if (err_total == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	// --------
	// Sequence
	// --------
	initial begin
		seed = 58;
		{nrst, reg_wr, reg_rd, idle_mode, chip_reset_in} = 5'h00;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		rd(`WD_ADDR_CTRL, 8'h00);
		rd(`WD_ADDR_KEY, 8'h00);
		rd(8'h3C, 8'h00);
		wr(`WD_ADDR_CTRL, 8'hFF);
		rd(`WD_ADDR_CTRL, 8'hF0);
		keys(`WD_KEY_SR1, `WD_KEY_SR2, 8'h04);
		keys(`WD_KEY_SR1, `WD_KEY_EN2, 8'h06);
		keys(`WD_KEY_EN1, `WD_KEY_SR2, 8'h06);
		keys(`WD_KEY_EN2, 8'h00, 8'h06);
		repeat (4) begin
			b = byte_t'($random(seed));
			if (b == `WD_KEY_EN1 || b == `WD_KEY_SR1)
				b = 8'h00;
			keys(b, 8'h00, 8'h06);
		end
		wr(`WD_ADDR_CTRL, 8'h02);
		rd(`WD_ADDR_CTRL, 8'h02);
		// Start, then stop and drop a pending key by chip reset
		wr(`WD_ADDR_CTRL, 8'hE0);
		kick();
		rd(`WD_ADDR_CTRL, 8'hE1);
		wr(`WD_ADDR_KEY, `WD_KEY_SR1);
		chip_pulse();
		bit_is(wdog_running_flag, 1'b0);
		keys(`WD_KEY_SR2, 8'h00, 8'h06);
		// Service every ten cycles keeps it alive
		r0 = req_total;
		kick();
		repeat (6) begin
			repeat (6) @(posedge sys_clk);
			kick();
		end
		check(byte_t'(req_total - r0), 8'h00);
		chip_pulse();
		ps_tab[3] = byte_t'($random(seed)) & 8'h60;
		for (k = 0; k < 4; k++) begin
			p = exp_period(ps_tab[k]);
			timeout(ps_tab[k], 3000);
			check(byte_t'(n >= p && n <= p + 2), 8'h01);
			repeat (2) @(posedge sys_clk);
			rd(`WD_ADDR_CTRL, 8'h02);
		end
		// Frozen while idle, counting while idle otherwise
		idle_mode <= 1'b1;
		timeout(8'h10, 60);
		check({7'h00, wd_reset_req}, 8'h00);
		idle_mode <= 1'b0;
		wait_req(40);
		check({7'h00, wd_reset_req}, 8'h01);
		idle_mode <= 1'b1;
		timeout(8'h00, 40);
		check({7'h00, wd_reset_req}, 8'h01);
		idle_mode <= 1'b0;
		// Interrupt masked, enabled, cleared
		wr(`WD_ADDR_IRQ_CLR, 8'h07);
		keys(`WD_KEY_SR1, `WD_KEY_SR2, 8'h04);
		rd(`WD_ADDR_IRQ_STAT, 8'h01);
		bit_is(wd_irq, 1'b0);
		wr(`WD_ADDR_IRQ_EN, 8'h07);
		bit_is(wd_irq, 1'b1);
		wr(`WD_ADDR_IRQ_CLR, 8'h01);
		bit_is(wd_irq, 1'b0);
		keys(8'h33, 8'h00, 8'h06);
		rd(`WD_ADDR_IRQ_STAT, 8'h04);
		bit_is(wd_irq, 1'b1);
		wr(`WD_ADDR_IRQ_EN, 8'h03);
		bit_is(wd_irq, 1'b0);
		close_out();
	end
endmodule : watchdog_soft_reset_bench

// file: verilog/key_decoder.sv
`timescale 1ns/1ps
`include "wdog_consts.svh"
module key_decoder
	import wdog_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Key traffic
	key_if.decoder   kbus
);
	key_state_e state_q;
	key_state_e state_d;

	// Pair decode; results are one-cycle pulses
	always_comb begin
		state_d = state_q;
		kbus.kick = 1'b0;
		kbus.soft_req = 1'b0;
		kbus.bad_key = 1'b0;
		if (kbus.key_wr) begin
			case (state_q)
				KEY_IDLE: begin
					if (kbus.key_data == `WD_KEY_EN1) begin
						state_d = KEY_HAVE_EN;
					end else if (kbus.key_data == `WD_KEY_SR1) begin
						state_d = KEY_HAVE_SR;
					end else begin
						kbus.bad_key = 1'b1;
					end
				end
				KEY_HAVE_EN: begin
					state_d = KEY_IDLE;
					kbus.kick = (kbus.key_data == `WD_KEY_EN2);
					kbus.bad_key = (kbus.key_data != `WD_KEY_EN2);
				end
				KEY_HAVE_SR: begin
					state_d = KEY_IDLE;
					kbus.soft_req = (kbus.key_data == `WD_KEY_SR2);
					kbus.bad_key = (kbus.key_data != `WD_KEY_SR2);
				end
				default: begin
					state_d = KEY_IDLE;
				end
			endcase
		end
		// A reset from any source drops a half-written pair
		if (kbus.abort) begin
			state_d = KEY_IDLE;
		end
	end

	// Sequence state
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= KEY_IDLE;
		end else begin
			state_q <= state_d;
		end
	end
endmodule : key_decoder

// file: verilog/key_if.sv
`timescale 1ns/1ps
interface key_if;
	import wdog_pkg::*;
	logic  key_wr;
	byte_t key_data;
	logic  abort;
	logic  kick;
	logic  soft_req;
	logic  bad_key;
	modport decoder (input key_wr, key_data, abort,
		output kick, soft_req, bad_key);
	modport ctrl (output key_wr, key_data, abort,
		input kick, soft_req, bad_key);
endinterface : key_if

// file: verilog/watchdog_soft_reset.sv
`timescale 1ns/1ps
`include "wdog_consts.svh"
module watchdog_soft_reset
	import wdog_pkg::*;
#(
	parameter int BASE_CYCLES = `WD_BASE_CYCLES,
	parameter int CNT_W       = `WD_CNT_W
) (
	// Clock and reset
	input wire logic  sys_clk,
	input wire logic  nrst,
	// Register port
	input wire byte_t reg_addr,
	input wire byte_t reg_wdata,
	input wire logic  reg_wr,
	input wire logic  reg_rd,
	output byte_t     reg_rdata,
	// Device state
	input wire logic  idle_mode,
	input wire logic  chip_reset_in,
	// Reset request, interrupt and running flag
	output logic      wd_reset_req,
	output logic      wd_irq,
	output logic      wdog_running_flag
);

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------

	// Write hit on one register address
	function automatic logic wr_hit(
		input logic  wr,
		input byte_t addr,
		input byte_t target
	);
		wr_hit = wr && (addr == target);
	endfunction : wr_hit

	// Sticky flag: setting event wins, a written 0 clears, 1 is ignored.
	// Shared by both reset-cause flags so they cannot drift apart.
	function automatic logic flag_next(
		input logic cur,
		input logic set,
		input logic wr,
		input logic wbit
	);
		if (set) begin
			flag_next = 1'b1;
		end else if (wr && !wbit) begin
			flag_next = 1'b0;
		end else begin
			flag_next = cur;
		end
	endfunction : flag_next

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------

	key_if kbus ();

	psel_t prescale_q;
	logic  wdog_idle_freeze_q;
	logic  soft_reset_flag_q;
	logic  wdog_overflow_flag_q;
	logic  running_q;
	logic  reset_req_q;
	irq_t  irq_stat_q;
	irq_t  irq_en_q;
	byte_t rdata_q;

	logic  key_wr;
	logic  ctrl_wr;
	logic  clr_wr;
	logic  en_wr;
	logic  soft_evt;
	logic  bad_evt;
	logic  ovf_evt;
	logic  own_reset;
	logic  any_reset;
	logic  freeze;
	irq_t  irq_set;
	irq_t  irq_clr;
	byte_t ctrl_view;
	byte_t rdata_d;

	// ------------------------------------------------------------
	// Register write decode
	// ------------------------------------------------------------

	// Key register has no storage; it only feeds the decoder
	assign key_wr  = wr_hit(reg_wr, reg_addr, `WD_ADDR_KEY);
	assign ctrl_wr = wr_hit(reg_wr, reg_addr, `WD_ADDR_CTRL);
	assign clr_wr  = wr_hit(reg_wr, reg_addr, `WD_ADDR_IRQ_CLR);
	assign en_wr   = wr_hit(reg_wr, reg_addr, `WD_ADDR_IRQ_EN);

	// ------------------------------------------------------------
	// Key sequence decoder
	// ------------------------------------------------------------

	// Key traffic toward the decoder
	assign kbus.key_wr   = key_wr;
	assign kbus.key_data = reg_wdata;
	assign kbus.abort    = any_reset;

	key_decoder u_key_decoder (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.kbus    (kbus.decoder)
	);

	// Decoder results; soft reset works with counter stopped
	assign soft_evt = kbus.soft_req;
	assign bad_evt  = kbus.bad_key;

	// ------------------------------------------------------------
	// Watchdog counter
	// ------------------------------------------------------------

	// Freeze only while idle and the option asks for it
	assign freeze = wdog_idle_freeze_q && idle_mode;

	wdog_counter #(
		.BASE_CYCLES (BASE_CYCLES),
		.CNT_W       (CNT_W)
	) u_wdog_counter (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.run      (running_q),
		.freeze   (freeze),
		.restart  (kbus.kick),
		.psel     (prescale_q),
		.overflow (ovf_evt)
	);

	// ------------------------------------------------------------
	// Reset generation
	// ------------------------------------------------------------

	// Reset sources raised by this block.
	// All three act in the same cycle as their event, so the key
	// decoder and running state are cleared on the same edge the pulse shows.
	// The surrounding device decides how long its own reset lasts;
	// this block only flags the request for one cycle.
	assign own_reset = soft_evt || bad_evt || ovf_evt;

	// Any reset, ours or from elsewhere in the device
	assign any_reset = own_reset || chip_reset_in;

	// Registered request so the pulse is glitch free
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			reset_req_q <= 1'b0;
		end else begin
			reset_req_q <= own_reset;
		end
	end

	assign wd_reset_req = reset_req_q;

	// ------------------------------------------------------------
	// Running state
	// ------------------------------------------------------------

	// Reset wins over a kick in the same cycle.
	// A kick that closes a pair while a reset is raised is lost;
	// software must write the pair again after the reset.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			running_q <= 1'b0;
		end else if (any_reset) begin
			running_q <= 1'b0;
		end else if (kbus.kick) begin
			running_q <= 1'b1;
		end
	end

	assign wdog_running_flag = running_q;

	// ------------------------------------------------------------
	// Control register: prescale and idle option
	// ------------------------------------------------------------

	// Prescale select; a device reset returns it to default
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			prescale_q <= `WD_PS_RST;
		end else if (any_reset) begin
			prescale_q <= `WD_PS_RST;
		end else if (ctrl_wr) begin
			prescale_q <= reg_wdata[`WD_CTRL_PS_HI:`WD_CTRL_PS_LO];
		end
	end

	// Idle-freeze option
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wdog_idle_freeze_q <= 1'b0;
		end else if (any_reset) begin
			wdog_idle_freeze_q <= 1'b0;
		end else if (ctrl_wr) begin
			wdog_idle_freeze_q <= reg_wdata[`WD_CTRL_IDLE];
		end
	end

	// ------------------------------------------------------------
	// Control register: reset-cause flags
	// ------------------------------------------------------------

	// Flags survive the reset they report; only power-up or a written 0 clears them.
	// Writing 0 clears; setting event wins over a clear.
	// Software that writes back a stale image of the register with
	// a 0 in a flag bit may lose a cause that arrived meanwhile.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			soft_reset_flag_q <= 1'b0;
		end else begin
			soft_reset_flag_q <= flag_next(soft_reset_flag_q,
				soft_evt || bad_evt, ctrl_wr,
				reg_wdata[`WD_CTRL_SOFT]);
		end
	end

	// Overflow flag; a good soft key leaves it alone
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wdog_overflow_flag_q <= 1'b0;
		end else begin
			wdog_overflow_flag_q <= flag_next(wdog_overflow_flag_q,
				ovf_evt || bad_evt, ctrl_wr,
				reg_wdata[`WD_CTRL_OVF]);
		end
	end

	// ------------------------------------------------------------
	// Interrupt status, clear and enable
	// ------------------------------------------------------------

	// Event vector in status-bit order
	always_comb begin
		irq_set = '0;
		irq_set[`WD_IRQ_SOFT] = soft_evt;
		irq_set[`WD_IRQ_OVF]  = ovf_evt;
		irq_set[`WD_IRQ_BAD]  = bad_evt;
	end

	// Write-one-to-clear mask
	assign irq_clr = clr_wr ? reg_wdata[2:0] : '0;

	// Sticky status; set beats clear per bit.
	// Unlike the cause flags, status bits split a bad key from an
	// overflow, so software can tell all three sources apart.
	for (genvar i = 0; i < 3; i++) begin : g_irq_stat
		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				irq_stat_q[i] <= 1'b0;
			end else if (irq_set[i]) begin
				irq_stat_q[i] <= 1'b1;
			end else if (irq_clr[i]) begin
				irq_stat_q[i] <= 1'b0;
			end
		end
	end

	// Interrupt enables
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			irq_en_q <= '0;
		end else if (en_wr) begin
			irq_en_q <= reg_wdata[2:0];
		end
	end

	// Level interrupt while any enabled status bit is set
	assign wd_irq = |(irq_stat_q & irq_en_q);

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------

	// Control register image; bit 3 reserved reads zero.
	// The running bit is shown but never written from the bus.
	always_comb begin
		ctrl_view = '0;
		ctrl_view[`WD_CTRL_PS_HI:`WD_CTRL_PS_LO] = prescale_q;
		ctrl_view[`WD_CTRL_IDLE] = wdog_idle_freeze_q;
		ctrl_view[`WD_CTRL_SOFT] = soft_reset_flag_q;
		ctrl_view[`WD_CTRL_OVF]  = wdog_overflow_flag_q;
		ctrl_view[`WD_CTRL_RUN]  = running_q;
	end

	// Read mux; write-only and unmapped addresses read zero.
	// Reads have no side effects, so polling status is always safe.
	// The key register returns zero so no half pair can be seen.
	always_comb begin
		rdata_d = '0;
		if (reg_rd) begin
			case (reg_addr)
				`WD_ADDR_CTRL: begin
					rdata_d = ctrl_view;
				end
				`WD_ADDR_IRQ_STAT: begin
					rdata_d = {5'h00, irq_stat_q};
				end
				`WD_ADDR_IRQ_EN: begin
					rdata_d = {5'h00, irq_en_q};
				end
				default: begin
					rdata_d = '0;
				end
			endcase
		end
	end

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

endmodule : watchdog_soft_reset

// file: verilog/wdog_consts.svh
`ifndef WDOG_CONSTS_SVH
`define WDOG_CONSTS_SVH
// Function
// - Key pair 5AH then A5H written to the key register resets the device.
// - Soft-reset key pair works even while the watchdog is stopped.
// - Keyed soft reset sets only the soft-reset flag; software clears it.
// - Any other key write resets at once and sets both reset flags.
// - Prescale select sets time-out: 0 gives 16K cycles, 7 gives 2048K.
// - Idle-freeze 0 counts in idle; idle-freeze 1 holds count while idle.
// - Counter overflow resets the device and sets the overflow flag.
// - Running bit is read-only, shows counter state; writes ignored.
// - Every reset stops the counter; only key pair 1EH/E1H restarts it.
// - Key register write-only at A6H; control register at A7H.

// Register addresses
`define WD_ADDR_KEY      8'hA6
`define WD_ADDR_CTRL     8'hA7
`define WD_ADDR_IRQ_STAT 8'hA8
`define WD_ADDR_IRQ_CLR  8'hA9
`define WD_ADDR_IRQ_EN   8'hAA

// Key bytes
`define WD_KEY_EN1       8'h1E
`define WD_KEY_EN2       8'hE1
`define WD_KEY_SR1       8'h5A
`define WD_KEY_SR2       8'hA5

// Control register fields
`define WD_CTRL_PS_HI    7
`define WD_CTRL_PS_LO    5
`define WD_CTRL_IDLE     4
`define WD_CTRL_SOFT     2
`define WD_CTRL_OVF      1
`define WD_CTRL_RUN      0
`define WD_PS_RST        3'h0

// Interrupt status, clear and enable fields
`define WD_IRQ_SOFT      0
`define WD_IRQ_OVF       1
`define WD_IRQ_BAD       2

// Time-out base and counter width
`define WD_BASE_CYCLES   16384
`define WD_CNT_W         21
`endif

// file: verilog/wdog_counter.sv
`timescale 1ns/1ps
module wdog_counter
	import wdog_pkg::*;
#(
	parameter int BASE_CYCLES = 16384,
	parameter int CNT_W       = 21
) (
	// Clock and reset
	input wire logic  sys_clk,
	input wire logic  nrst,
	// Control
	input wire logic  run,
	input wire logic  freeze,
	input wire logic  restart,
	input wire psel_t psel,
	// Event
	output logic      overflow
);
	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] last;

	// Period doubles per select step
	assign last = CNT_W'((BASE_CYCLES << psel) - 1);
	assign overflow = run && !restart && !freeze && (count_q == last);

	// Count; restart and stop both zero it
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			count_q <= '0;
		end else if (restart || !run) begin
			count_q <= '0;
		end else if (freeze) begin
			count_q <= count_q;
		end else if (count_q == last) begin
			count_q <= '0;
		end else begin
			count_q <= count_q + 1'b1;
		end
	end
endmodule : wdog_counter

// file: verilog/wdog_pkg.sv
package wdog_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [2:0] psel_t;
	typedef logic [2:0] irq_t;
	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_HAVE_EN,
		KEY_HAVE_SR
	} key_state_e;
endpackage : wdog_pkg
